//--- hmp_defines.svh
// Functional notes
// - Host transfers reach only program and data memory; of the mapped registers, the host sets only the overlay, through the address latch.
// - Bit 15 set: bits 7:0 are overlay, bits 14:8 zero, word to overlay.
// - Bit 15 clear: bits 13:0 are start address, bit 14 picks memory.
// - One 16-bit multiplexed bus carries address and data, including 24-bit program words.
// - Host strobes are accepted asynchronously, also while the core runs full speed.
// - Latched address increments after every data-memory access and after the second half of each program word, for sequential blocks.
// - Host drives 14-bit address and 1-bit type only while acknowledge is asserted.
// - Address captured on address-latch falling edge or on select edge.
// - Select plus read or write strobe requests transfer; one cycle synchronises it.
// - Memory access follows in one further cycle stolen from the core.
// - Core can set start address and type by writing the address register.
// - Control and overlay register sits in core data space at 0x3FE0.
// - Host has no path to read back the latched address.
// - System register bit 14 selects between two short-read timing variants.
// - Mode inputs C=1, B=0, A=1 select booting through the host port.
// - During host boot, execution held until program memory location 0 written.
`ifndef HMP_DEFINES_SVH
`define HMP_DEFINES_SVH

`define HMP_CTRL_ADDR      14'h3FE0
`define HMP_SYSCTL_ADDR    14'h3FE7
`define HMP_REG_BASE       14'h3FE0
`define HMP_SHORT_READ_BIT 14
`define HMP_WORD_SEL_BIT   15
`define HMP_SPACE_BIT      14
`define HMP_OVL_RESET      16'h0000
`define HMP_BOOT_MODE_HOST 3'h5
`define HMP_BOOT_ADDR      14'h0000
`define HMP_ADDR_STEP      14'h0001

`endif

//--- hmp_pkg.sv
package hmp_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_FINISH} hmp_state_type;

	typedef struct packed {
		logic prev;
		logic cur;
	} hmp_edge_type;

	typedef struct packed {
		hmp_state_type st;
		logic          ack_n;
		logic [13:0]   addr;
		logic          space_dm;
		logic [15:0]   ovl;
		logic          short_sel;
		logic          half;
		logic          op_wr;
		logic [15:0]   bus_q;
		logic [15:0]   wdata;
		logic [15:0]   pm_hi;
		logic [7:0]    pm_lo;
		logic [15:0]   dout;
		logic          dout_ok;
		logic          drive;
		logic          core_hold;
		logic          boot_hold;
		logic          strap_done;
		logic          core_pend;
		logic          core_reg;
		logic [15:0]   core_regval;
		logic [15:0]   core_rdata;
	} hmp_top_type;

endpackage

//--- hmp_edge.sv
`timescale 1ns/10ps
module hmp_edge
	import hmp_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Strobe in
	input  wire logic din,
	// Registered level and edges
	output logic      lvl,
	output logic      fall,
	output logic      rise
);
	hmp_edge_type r;
	hmp_edge_type n;

	always_comb begin
		n = r;
		n.cur = din;
		n.prev = r.cur;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{prev: 1'b1, cur: 1'b1};
		end else begin
			r <= n;
		end
	end

	assign lvl  = r.cur;
	assign fall = r.prev & ~r.cur;
	assign rise = ~r.prev & r.cur;
endmodule

//--- hmp_mem.sv
`timescale 1ns/10ps
module hmp_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16384
) (
	// Clock
	input  wire logic                     clk,
	// Access
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] addr,
	input  wire logic [WIDTH-1:0]         wdata,
	output logic      [WIDTH-1:0]         rdata
);
	typedef struct packed {
		logic [WIDTH-1:0] rdata;
	} hmp_mem_type;

	logic [WIDTH-1:0] mem [DEPTH];
	hmp_mem_type      r;
	hmp_mem_type      n;

	always_comb begin
		n = r;
		n.rdata = mem[addr];
	end

	always_ff @(posedge clk) begin
		r <= n;
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	assign rdata = r.rdata;
endmodule

//--- hmp_host_port.sv
`timescale 1ns/10ps
`include "hmp_defines.svh"
module hmp_host_port
	import hmp_pkg::*;
#(
	parameter int PM_DEPTH = 16384,
	parameter int DM_DEPTH = 16384
) (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// Host port
	input  wire logic [15:0] HOST_ADDR_DATA_BUS_IN,
	output logic      [15:0] HOST_ADDR_DATA_BUS_OUT,
	output logic             HOST_ADDR_DATA_BUS_OE_N,
	input  wire logic        PORT_SELECT_N,
	input  wire logic        ADDRESS_LATCH_STROBE,
	input  wire logic        HOST_READ_STROBE_N,
	input  wire logic        HOST_WRITE_STROBE_N,
	output logic             HOST_ACKNOWLEDGE_N,
	// Boot mode straps
	input  wire logic        MODE_A,
	input  wire logic        MODE_B,
	input  wire logic        MODE_C,
	// Core data memory bus
	input  wire logic        CORE_DM_SEL,
	input  wire logic        CORE_DM_WE,
	input  wire logic [13:0] CORE_DM_ADDR,
	input  wire logic [15:0] CORE_DM_WDATA,
	output logic      [15:0] CORE_DM_RDATA,
	// Core program fetch
	input  wire logic [13:0] CORE_PM_ADDR,
	output logic      [23:0] CORE_PM_RDATA,
	// Core hold for stolen cycles and boot
	output logic             CORE_HOLD
);
	hmp_top_type r;
	hmp_top_type n;

	logic        sel_lvl;
	logic        sel_rise;
	logic        ial_lvl;
	logic        ial_fall;
	logic        rd_lvl;
	logic        rd_fall;
	logic        wr_fall;
	logic        host_latch;
	logic        core_wr;
	logic        core_ctrl_wr;
	logic        latch_go;
	logic [15:0] latch_val;
	logic        acc_go;
	logic        port_acc;
	logic        dm_we;
	logic [13:0] dm_addr;
	logic [15:0] dm_wdata;
	logic [15:0] dm_rdata;
	logic        pm_we;
	logic [13:0] pm_addr;
	logic [23:0] pm_rdata;
	logic        word_done;

	hmp_edge u_sel (.clk(SYS_CLK), .rst_n(RST_N), .din(PORT_SELECT_N),
		.lvl(sel_lvl), .fall(), .rise(sel_rise));
	hmp_edge u_ial (.clk(SYS_CLK), .rst_n(RST_N), .din(~ADDRESS_LATCH_STROBE),
		.lvl(ial_lvl), .fall(), .rise(ial_fall));
	hmp_edge u_rd (.clk(SYS_CLK), .rst_n(RST_N), .din(HOST_READ_STROBE_N),
		.lvl(rd_lvl), .fall(rd_fall), .rise());
	hmp_edge u_wr (.clk(SYS_CLK), .rst_n(RST_N), .din(HOST_WRITE_STROBE_N),
		.lvl(), .fall(wr_fall), .rise());

	// Latch strobe is inverted into u_ial, so its rise is the strobe's fall
	assign host_latch   = (ial_fall & ~sel_lvl) | (sel_rise & ~ial_lvl);
	assign core_wr      = CORE_DM_SEL & CORE_DM_WE & ~r.core_hold;
	assign core_ctrl_wr = core_wr & (CORE_DM_ADDR == `HMP_CTRL_ADDR);
	assign latch_go     = host_latch | core_ctrl_wr;
	assign latch_val    = core_ctrl_wr ? CORE_DM_WDATA : r.bus_q;
	assign acc_go       = (rd_fall | wr_fall) & ~sel_lvl & (r.st == ST_IDLE);
	assign port_acc     = (r.st == ST_ACCESS);

	// Host cannot reach the mapped register window at the top of data space
	assign dm_we    = (port_acc & r.op_wr & r.space_dm & (r.addr < `HMP_REG_BASE)) |
		(core_wr & (CORE_DM_ADDR < `HMP_REG_BASE) & ~port_acc);
	assign dm_addr  = (port_acc & r.space_dm) ? r.addr : CORE_DM_ADDR;
	assign dm_wdata = port_acc ? r.wdata : CORE_DM_WDATA;
	assign pm_we    = port_acc & r.op_wr & ~r.space_dm & r.half;
	assign pm_addr  = (port_acc & ~r.space_dm) ? r.addr : CORE_PM_ADDR;
	assign word_done = r.space_dm | r.half;

	hmp_mem #(.WIDTH(16), .DEPTH(DM_DEPTH)) u_dm (
		.clk(SYS_CLK), .we(dm_we), .addr(dm_addr), .wdata(dm_wdata), .rdata(dm_rdata));
	hmp_mem #(.WIDTH(24), .DEPTH(PM_DEPTH)) u_pm (
		.clk(SYS_CLK), .we(pm_we), .addr(pm_addr),
		.wdata({r.pm_hi, r.wdata[7:0]}), .rdata(pm_rdata));

	always_comb begin
		n = r;
		n.bus_q = HOST_ADDR_DATA_BUS_IN;
		if (!r.strap_done) begin
			n.strap_done = 1'b1;
			n.boot_hold = ({MODE_C, MODE_B, MODE_A} == `HMP_BOOT_MODE_HOST);
		end
		case (r.st)
			ST_IDLE: begin
				if (acc_go) begin
					n.st = ST_ACCESS;
					n.ack_n = 1'b1;
					n.op_wr = wr_fall;
					n.wdata = r.bus_q;
					if (rd_fall) begin
						n.dout_ok = 1'b0;
					end
				end
			end
			ST_ACCESS: begin
				n.st = ST_FINISH;
			end
			ST_FINISH: begin
				n.st = ST_IDLE;
				n.ack_n = 1'b0;
				if (!r.op_wr) begin
					n.dout_ok = 1'b1;
					if (r.space_dm) begin
						n.dout = dm_rdata;
					end else if (r.half) begin
						n.dout = {8'h00, r.pm_lo};
					end else begin
						n.dout = pm_rdata[23:8];
						n.pm_lo = pm_rdata[7:0];
					end
				end else if (!r.space_dm && !r.half) begin
					n.pm_hi = r.wdata;
				end
				if (!r.space_dm) begin
					n.half = ~r.half;
				end
				if (word_done) begin
					n.addr = r.addr + `HMP_ADDR_STEP;
				end
				if (r.op_wr && !r.space_dm && r.half && r.addr == `HMP_BOOT_ADDR) begin
					n.boot_hold = 1'b0;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		if (latch_go) begin
			if (latch_val[`HMP_WORD_SEL_BIT]) begin
				n.ovl = {8'h00, latch_val[7:0]};
			end else begin
				n.addr = latch_val[13:0];
				n.space_dm = latch_val[`HMP_SPACE_BIT];
				n.half = 1'b0;
			end
		end
		if (core_wr && CORE_DM_ADDR == `HMP_SYSCTL_ADDR) begin
			n.short_sel = CORE_DM_WDATA[`HMP_SHORT_READ_BIT];
		end
		// Short-read variant: set drives held data at once, clear waits for fresh data
		n.drive = ~rd_lvl & ~sel_lvl & (r.short_sel | n.dout_ok);
		n.core_hold = n.boot_hold | (n.st == ST_ACCESS);
		// Core reads: the address register is never a read source
		n.core_pend = CORE_DM_SEL & ~CORE_DM_WE & ~r.core_hold;
		n.core_reg = CORE_DM_ADDR >= `HMP_REG_BASE;
		if (CORE_DM_ADDR == `HMP_CTRL_ADDR) begin
			n.core_regval = r.ovl;
		end else if (CORE_DM_ADDR == `HMP_SYSCTL_ADDR) begin
			n.core_regval = 16'h0000;
			n.core_regval[`HMP_SHORT_READ_BIT] = r.short_sel;
		end else begin
			n.core_regval = 16'h0000;
		end
		if (r.core_pend) begin
			n.core_rdata = r.core_reg ? r.core_regval : dm_rdata;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.ack_n <= 1'b0;
			r.ovl <= `HMP_OVL_RESET;
		end else begin
			r <= n;
		end
	end

	assign HOST_ADDR_DATA_BUS_OUT  = r.dout;
	assign HOST_ADDR_DATA_BUS_OE_N = ~r.drive;
	assign HOST_ACKNOWLEDGE_N      = r.ack_n;
	assign CORE_DM_RDATA           = r.core_rdata;
	assign CORE_PM_RDATA           = pm_rdata;
	assign CORE_HOLD               = r.core_hold;

	sequence s_busy_then_ready;
		HOST_ACKNOWLEDGE_N [*2] ##1 !HOST_ACKNOWLEDGE_N;
	endsequence

	sequence s_steal;
		(r.st == ST_ACCESS) && CORE_HOLD ##1 (r.st == ST_FINISH);
	endsequence

	AST_ACK_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc_go |=> s_busy_then_ready)
		else $error("acknowledge did not drop and return in three cycles");

	AST_SYNC_THEN_STEAL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc_go |=> s_steal)
		else $error("access did not follow synchronisation by one stolen cycle");

	AST_REQ_NEEDS_SELECT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(HOST_ACKNOWLEDGE_N) |-> $past(~sel_lvl & (rd_fall | wr_fall)))
		else $error("transfer started without select and strobe");

	AST_NO_REG_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(port_acc && dm_we) |-> (r.addr < `HMP_REG_BASE))
		else $error("host write reached the register window");

	AST_INCREMENT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		((r.st == ST_FINISH) && word_done && !latch_go) |=>
		(r.addr == $past(r.addr) + `HMP_ADDR_STEP))
		else $error("address did not increment after access");

	AST_ADDR_LATCH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(latch_go && !latch_val[15]) |=>
		(r.addr == $past(latch_val[13:0])) && (r.space_dm == $past(latch_val[14])))
		else $error("start address not latched");

	AST_OVERLAY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(latch_go && latch_val[15]) |=> (r.ovl == {8'h00, $past(latch_val[7:0])}))
		else $error("overlay word not stored");

	AST_HOST_LATCH_EDGE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(ial_fall && !sel_lvl && !core_ctrl_wr && !r.bus_q[15]) |=>
		(r.addr == $past(r.bus_q[13:0])))
		else $error("latch strobe edge did not capture bus");

	AST_BOOT_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(r.boot_hold && !(r.st == ST_FINISH && r.op_wr && !r.space_dm && r.half &&
		r.addr == `HMP_BOOT_ADDR)) |=> (r.boot_hold && CORE_HOLD))
		else $error("boot hold released before program word 0 written");

	AST_SHORT_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!r.short_sel && !r.dout_ok && !n.dout_ok) |=> HOST_ADDR_DATA_BUS_OE_N)
		else $error("bus driven before read data ready");
endmodule

//--- hmp_host_model.sv
`timescale 1ns/10ps
module hmp_host_model (
	// Clock
	input  wire logic        clk,
	// Pins toward the port
	output logic      [15:0] bus_to_dev,
	input  wire logic [15:0] bus_from_dev,
	input  wire logic        dev_oe_n,
	output logic             sel_n,
	output logic             als,
	output logic             rd_n,
	output logic             wr_n,
	input  wire logic        ack_n,
	// Read results
	output logic             rd_valid,
	output logic      [15:0] rd_data
);
	logic [15:0] hv = 16'h0000;
	logic        drv = 1'b0;
	// A released bus shows the inverse of the last value, so stale data never passes
	assign bus_to_dev = !dev_oe_n ? bus_from_dev : (drv ? hv : ~hv);
	initial begin
		sel_n = 1'b1;
		als = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		rd_valid = 1'b0;
		rd_data = 16'h0000;
	end
	task automatic wait_ack(input logic lvl);
		for (int n = 0; n < 20 && ack_n !== lvl; n++) @(negedge clk);
	endtask
	task automatic begin_op(input logic [15:0] v);
		wait_ack(1'b0);
		hv = v;
		drv = 1'b1;
		sel_n = 1'b0;
	endtask
	task automatic latch(input logic [15:0] v);
		begin_op(v);
		als = 1'b1;
		@(negedge clk);
		als = 1'b0;
		repeat (3) @(negedge clk);
		sel_n = 1'b1;
		drv = 1'b0;
		@(negedge clk);
	endtask
	task automatic xfer(input logic wr, input logic [15:0] v);
		begin_op(v);
		drv = wr;
		if (wr) wr_n = 1'b0; else rd_n = 1'b0;
		wait_ack(1'b1);
		wait_ack(1'b0);
		rd_data = dev_oe_n ? 16'hXXXX : bus_from_dev;
		rd_valid = !wr;
		wr_n = 1'b1;
		rd_n = 1'b1;
		sel_n = 1'b1;
		drv = 1'b0;
		@(negedge clk);
		rd_valid = 1'b0;
	endtask
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb
	import hmp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  mode = 3'h5;
	logic [15:0] bus_in, bus_out, rd, core_d, r;
	logic        oe_n, sel_n, als, rd_n, wr_n, ack_n, hold, rv;
	logic        dm_sel = 1'b0;
	logic        dm_we = 1'b0;
	logic [13:0] dm_addr = 14'h0000;
	logic [15:0] dm_wdata = 16'h0000;
	logic [15:0] dm_rdata;
	logic [13:0] pm_addr = 14'h0000;
	logic [23:0] pm_rdata;
	logic [15:0] seed = 16'h54DE;
	logic [15:0] exp_q[$];
	logic [15:0] w[4];
	logic        core_v = 1'b0;
	int          error_cnt = 0;
	int          comparisons = 0;
	always #12.5 clk = ~clk;
	hmp_host_port dut (.SYS_CLK(clk), .RST_N(rst_n), .HOST_ADDR_DATA_BUS_IN(bus_in),
		.HOST_ADDR_DATA_BUS_OUT(bus_out), .HOST_ADDR_DATA_BUS_OE_N(oe_n),
		.PORT_SELECT_N(sel_n), .ADDRESS_LATCH_STROBE(als), .HOST_READ_STROBE_N(rd_n),
		.HOST_WRITE_STROBE_N(wr_n), .HOST_ACKNOWLEDGE_N(ack_n), .MODE_A(mode[0]),
		.MODE_B(mode[1]), .MODE_C(mode[2]), .CORE_DM_SEL(dm_sel), .CORE_DM_WE(dm_we),
		.CORE_DM_ADDR(dm_addr), .CORE_DM_WDATA(dm_wdata), .CORE_DM_RDATA(dm_rdata),
		.CORE_PM_ADDR(pm_addr), .CORE_PM_RDATA(pm_rdata), .CORE_HOLD(hold));
	hmp_host_model host (.clk(clk), .bus_to_dev(bus_in), .bus_from_dev(bus_out),
		.dev_oe_n(oe_n), .sel_n(sel_n), .als(als), .rd_n(rd_n), .wr_n(wr_n),
		.ack_n(ack_n), .rd_valid(rv), .rd_data(rd));
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic core_wr(input logic [13:0] a, input logic [15:0] d);
		dm_sel = 1'b1;
		dm_we = 1'b1;
		dm_addr = a;
		dm_wdata = d;
		@(negedge clk);
		dm_sel = 1'b0;
		dm_we = 1'b0;
		@(negedge clk);
	endtask
	task automatic core_rd(input logic [13:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		dm_sel = 1'b1;
		dm_addr = a;
		@(negedge clk);
		dm_sel = 1'b0;
		repeat (2) @(negedge clk);
		core_d = dm_rdata;
		core_v = 1'b1;
		@(negedge clk);
		core_v = 1'b0;
	endtask
	task automatic host_rd(input logic [15:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, 16'h0000);
	endtask
	// Results are matched in order against the notes left by the drivers
	always @(posedge clk) begin
		if (rv) check(24'(rd), 24'(exp_q.pop_front()));
		if (core_v) check(24'(core_d), 24'(exp_q.pop_front()));
	end
	task automatic close_out();
		$display("Mismatches %0d in %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check(24'(ack_n), 24'h000000);
		check(24'(oe_n), 24'h000001);
		repeat (2) @(negedge clk);
		check(24'(hold), 24'h000001);
		w[0] = rnd();
		w[1] = rnd();
		host.latch(16'h0000);
		host.xfer(1'b1, w[0]);
		check(24'(hold), 24'h000001);
		host.xfer(1'b1, w[1]);
		repeat (2) @(negedge clk);
		check(24'(hold), 24'h000000);
		check(pm_rdata, {w[0], w[1][7:0]});
		// Next program word follows without a new latch; fetch it from the core side
		host.xfer(1'b1, w[1]);
		host.xfer(1'b1, w[0]);
		pm_addr = 14'h0001;
		@(negedge clk);
		check(pm_rdata, {w[1], w[0][7:0]});
		host.latch(16'h0000);
		host_rd(w[0]);
		host_rd({8'h00, w[1][7:0]});
		host.latch(16'h4010);
		for (int i = 0; i < 4; i++) begin
			w[i] = rnd();
			host.xfer(1'b1, w[i]);
		end
		host.latch(16'h4010);
		for (int i = 0; i < 4; i++) host_rd(w[i]);
		core_rd(14'h0012, w[2]);
		// Overlay fields must stay zero, so show the overlay word leaves the address alone
		host.latch(16'h4011);
		host.latch(16'h8000);
		core_rd(14'h3FE0, 16'h0000);
		host_rd(w[1]);
		host.latch(16'h7FE0);
		host.xfer(1'b1, 16'hFFFF);
		core_rd(14'h3FE0, 16'h0000);
		core_wr(14'h3FE0, 16'h4020);
		core_rd(14'h3FE0, 16'h0000);
		r = rnd();
		host.xfer(1'b1, r);
		core_rd(14'h0020, r);
		core_wr(14'h3FE7, 16'h4000);
		core_rd(14'h3FE7, 16'h4000);
		host.latch(16'h4010);
		host_rd(w[0]);
		// Second reset with straps away from host boot: core must run free
		rst_n = 1'b0;
		mode = 3'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check(24'(ack_n), 24'h000000);
		check(24'(oe_n), 24'h000001);
		repeat (2) @(negedge clk);
		check(24'(hold), 24'h000000);
		core_rd(14'h0020, r);
		repeat (4) @(negedge clk);
		close_out();
	end
endmodule
